// ===== bench/arx_ctrl_top_tb_top.sv
// Self-checking bench for the delay control and test-channel block
// Assumes the loop model on the far side and an APB master here
`timescale 1ns/1ns
module arx_ctrl_top_tb_top;
  localparam logic [8:0] BT = 9'h0B4;
  logic MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic PREADY, PSLVERR, IRQ, RX_RESET, TX_RESET, TX_DLY_RDY, RIU_VALID, se;
  logic TOP_RESET_IN = 1'b0, RX_DLY_RDY = 1'b1;
  logic [1:0] TX_DLY_RDY_NIB = 2'h0;
  logic RX_EN_VTC, TX_EN_VTC;
  logic [8:0] sim_bt;
  logic [5:0] RX_CE, RX_INC, RX_LOAD;
  logic [53:0] RX_CNTVALUEIN;
  logic [15:0] RIU_RD_DATA;
  logic [8:0] BIT_TIME_TAPS;
  logic [23:0] TX_WORD, RX_WORD;
  logic [2:0] TX_VALID, RX_VALID, PAT_VALID, ERR_PULSE, pulse_seen, pv;
  int err_count = 0, samples_checked = 0, n;
  always #4 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    pulse_seen <= RST ? 3'h0 : pulse_seen | ERR_PULSE;
  end
  arx_ctrl_top #(.NCH(3), .W(8), .NTXN(2), .CNT_W(4), .SIM_MODE_FLAG(1'b0)) dut (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .TOP_RESET_IN(TOP_RESET_IN), .RX_RESET(RX_RESET),
    .TX_RESET(TX_RESET), .RX_EN_VTC(RX_EN_VTC), .TX_EN_VTC(TX_EN_VTC),
    .TX_DLY_RDY_NIB(TX_DLY_RDY_NIB), .TX_DLY_RDY(TX_DLY_RDY), .RX_DLY_RDY(RX_DLY_RDY),
    .RX_CE(RX_CE), .RX_INC(RX_INC),
    .RX_LOAD(RX_LOAD), .RX_CNTVALUEIN(RX_CNTVALUEIN), .RIU_ADDR(), .RIU_WR_DATA(),
    .RIU_WR_EN(), .RIU_NIBBLE_SEL(), .RIU_RD_DATA(RIU_RD_DATA), .RIU_VALID(RIU_VALID),
    .BIT_TIME_TAPS(BIT_TIME_TAPS), .TX_WORD(TX_WORD), .TX_VALID(TX_VALID),
    .RX_WORD(RX_WORD), .RX_VALID(RX_VALID), .PAT_VALID(PAT_VALID), .ERR_PULSE(ERR_PULSE)
  );
  arx_loop_model #(.BT_TAPS(BT)) far (
    .MCLK(MCLK), .RST(RST), .TX_WORD(TX_WORD), .TX_VALID(TX_VALID), .RX_WORD(RX_WORD),
    .RX_VALID(RX_VALID), .RIU_RD_DATA(RIU_RD_DATA), .RIU_VALID(RIU_VALID)
  );
  arx_ctrl_top #(.NCH(3), .W(8), .NTXN(2), .CNT_W(4), .SIM_MODE_FLAG(1'b1)) dut_sim (
    .MCLK(MCLK), .RST(RST), .PSEL(1'b0), .PENABLE(1'b0), .PWRITE(1'b0), .PADDR(8'h00),
    .PWDATA(32'h0000_0000), .PRDATA(), .PREADY(), .PSLVERR(), .IRQ(), .TOP_RESET_IN(1'b0),
    .RX_RESET(), .TX_RESET(), .RX_EN_VTC(), .TX_EN_VTC(), .TX_DLY_RDY_NIB(2'h0),
    .TX_DLY_RDY(), .RX_DLY_RDY(1'b0), .RX_CE(), .RX_INC(), .RX_LOAD(), .RX_CNTVALUEIN(),
    .RIU_ADDR(), .RIU_WR_DATA(), .RIU_WR_EN(), .RIU_NIBBLE_SEL(), .RIU_RD_DATA(16'h0000),
    .RIU_VALID(1'b0), .BIT_TIME_TAPS(sim_bt), .TX_WORD(), .TX_VALID(), .RX_WORD(24'h000000),
    .RX_VALID(3'h0), .PAT_VALID(), .ERR_PULSE()
  );
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge MCLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    q  = PRDATA;
    se = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 20) begin
      err_count++;
      final_report();
    end
  endtask : apb
  task automatic poll(input logic [7:0] a, input int b, input int lim);
    int i;
    i = 0;
    do begin
      apb(1'b0, a, 32'h0);
      i++;
    end while (q[b] !== 1'b1 && i < lim);
    if (q[b] !== 1'b1) begin
      err_count++;
      $display("[FAIL] poll %h exp 1 got %b", a, q[b]);
      final_report();
    end
  endtask : poll
  task automatic dly(input logic [1:0] ch, input logic [8:0] act, input logic [8:0] mon);
    apb(1'b1, 8'h04, {18'h0, ch, 3'h0, act});
    @(negedge MCLK);
    chk("act", {23'h0, act}, {23'h0, RX_CNTVALUEIN[ch*18+:9]});
    chk("mon", {23'h0, mon}, {23'h0, RX_CNTVALUEIN[ch*18+9+:9]});
    chk("load", 32'h3 << (ch*2), {26'h0, RX_LOAD});
  endtask : dly
  initial begin
    repeat (8) @(posedge MCLK);
    RST <= 1'b0;
    poll(8'h08, 9, 50);
    chk("bt_stat", {22'h0, 1'b1, BT}, {22'h0, q[9:0]});
    chk("bt_port", {23'h0, BT}, {23'h0, BIT_TIME_TAPS});
    chk("bt_sim", 32'h0000_00A0, {23'h0, sim_bt});
    apb(1'b1, 8'h00, 32'h0000_000F);
    repeat (2) @(negedge MCLK);
    chk("ctrl_bits", 32'hF, {28'h0, TX_EN_VTC, RX_EN_VTC, TX_RESET, RX_RESET});
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0C, 32'h1);
    TX_DLY_RDY_NIB <= 2'b01;
    repeat (3) @(posedge MCLK);
    chk("rst_off", 32'h0, {30'h0, RX_RESET, TX_RESET});
    chk("rdy_part", 32'h0, {31'h0, TX_DLY_RDY});
    TOP_RESET_IN   <= 1'b1;
    TX_DLY_RDY_NIB <= 2'b11;
    repeat (2) @(negedge MCLK);
    chk("rst_on", 32'h3, {30'h0, RX_RESET, TX_RESET});
    chk("rdy_all", 32'h1, {31'h0, TX_DLY_RDY});
    @(posedge MCLK);
    TOP_RESET_IN <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk("stat_rdy", 32'h3, {30'h0, q[11:10]});
    dly(2'h1, 9'd100, 9'd10);
    dly(2'h0, 9'd20, 9'd110);
    chk("step", 32'h0, {20'h0, RX_CE, RX_INC});
    pv = PAT_VALID;
    @(negedge MCLK);
    chk("pat_tgl", {29'h0, ~pv}, {29'h0, PAT_VALID});
    chk("no_err", 32'h0, {29'h0, pulse_seen});
    apb(1'b1, 8'h10, 32'h4);
    n = 0;
    do begin
      apb(1'b1, 8'h00, 32'h0000_0200);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      n++;
    end while (q !== 32'hF && n < 20);
    if (q !== 32'hF) begin
      err_count++;
      $display("[FAIL] cnt_fill exp %h got %h", 32'hF, q);
      final_report();
    end
    apb(1'b1, 8'h00, 32'h0);
    repeat (10) @(posedge MCLK);
    apb(1'b0, 8'h18, 32'h0);
    chk("cnt_sat", 32'hF, q);
    apb(1'b0, 8'h08, 32'h0);
    chk("sticky", 32'h2, {29'h0, q[18:16]});
    chk("pulses", 32'h2, {29'h0, pulse_seen});
    chk("irq_on", 32'h1, {31'h0, IRQ});
    apb(1'b1, 8'h00, 32'h0202_0000);
    apb(1'b1, 8'h0C, 32'h4);
    apb(1'b0, 8'h08, 32'h0);
    chk("sticky_clr", 32'h0, {29'h0, q[18:16]});
    apb(1'b0, 8'h18, 32'h0);
    chk("cnt_clr", 32'h0, q);
    chk("irq_off", 32'h0, {31'h0, IRQ});
    apb(1'b1, 8'h00, 32'h0000_0010);
    poll(8'h0C, 0, 50);
    chk("reread", {23'h0, BT}, {23'h0, BIT_TIME_TAPS});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    final_report();
  end
endmodule : arx_ctrl_top_tb_top

// ===== bench/arx_loop_model.sv
// Far-side stand-in: looped-back channels and lane control unit answers
// Assumes one clock shared with the block; loopback adds one cycle
`timescale 1ns/1ns
module arx_loop_model #(
  parameter logic [8:0] BT_TAPS = 9'h0B4
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic [23:0] TX_WORD,
  input  wire logic [2:0]  TX_VALID,
  output      logic [23:0] RX_WORD,
  output      logic [2:0]  RX_VALID,
  output      logic [15:0] RIU_RD_DATA,
  output      logic        RIU_VALID
);
  logic [2:0] cnt_r;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_r    <= 3'h0;
      RX_WORD  <= 24'h000000;
      RX_VALID <= 3'h0;
    end else begin
      cnt_r    <= cnt_r + 3'h1;
      RX_WORD  <= TX_WORD;
      RX_VALID <= TX_VALID;
    end
  end
  assign RIU_VALID   = (cnt_r == 3'h7);
  assign RIU_RD_DATA = RIU_VALID ? {7'h00, BT_TAPS} : {7'h7F, ~BT_TAPS};
endmodule : arx_loop_model

// ===== common/arx_chk_if.sv
// Signals between the control top and one test-pattern channel
// Assumes both ends run on the same clock and reset
`timescale 1ns/1ns
interface arx_chk_if #(
  parameter int unsigned W     = 8,
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst
);
  logic             inject;
  logic             sticky_clr;
  logic             chk_rst;
  logic [W-1:0]     rx_word;
  logic             rx_valid;
  logic [W-1:0]     tx_word;
  logic             tx_valid;
  logic             pat_valid;
  logic             err_pulse;
  logic             sticky;
  logic [CNT_W-1:0] err_cnt;

  modport mon (input clk, rst, tx_word, tx_valid, pat_valid, err_pulse, sticky, err_cnt,
               output inject, sticky_clr, chk_rst, rx_word, rx_valid);
  modport chk (input clk, rst, inject, sticky_clr, chk_rst, rx_word, rx_valid,
               output tx_word, tx_valid, pat_valid, err_pulse, sticky, err_cnt);
endinterface : arx_chk_if

// ===== common/arx_pkg.sv
// Constants, register map and state codes for the receive delay control block
// Assumes a single fabric clock domain and an APB register bus with 32-bit data
package arx_pkg;

  // ******************************************************
  // Widths and fixed values
  // ******************************************************
  localparam int unsigned ARX_TAP_W       = 9;
  localparam logic [8:0]  ARX_BT_SIM      = 9'h0A0;
  localparam logic [6:0]  ARX_PRBS_SEED   = 7'h7F;

  // ******************************************************
  // Register byte offsets
  // ******************************************************
  localparam logic [7:0]  ARX_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  ARX_OFF_DLY     = 8'h04;
  localparam logic [7:0]  ARX_OFF_STAT    = 8'h08;
  localparam logic [7:0]  ARX_OFF_ISTAT   = 8'h0C;
  localparam logic [7:0]  ARX_OFF_IMASK   = 8'h10;
  localparam logic [7:0]  ARX_OFF_CNT0    = 8'h14;

  // ******************************************************
  // Field positions and reset values
  // ******************************************************
  localparam int unsigned ARX_CTRL_RXRST_B = 0;
  localparam int unsigned ARX_CTRL_TXRST_B = 1;
  localparam int unsigned ARX_CTRL_RXVTC_B = 2;
  localparam int unsigned ARX_CTRL_TXVTC_B = 3;
  localparam int unsigned ARX_CTRL_REREAD_B = 4;
  localparam int unsigned ARX_CTRL_INJ_LSB = 8;
  localparam int unsigned ARX_CTRL_SCLR_LSB = 16;
  localparam int unsigned ARX_CTRL_CRST_LSB = 24;
  localparam logic [31:0] ARX_CTRL_WMASK  = 32'h0000_FF0F;
  localparam logic [31:0] ARX_CTRL_RST    = 32'h0000_0000;
  localparam int unsigned ARX_DLY_CH_LSB  = 12;
  localparam logic [13:0] ARX_DLY_RST     = 14'h0000;
  localparam int unsigned ARX_STAT_BTV_B  = 9;
  localparam int unsigned ARX_STAT_TXR_B  = 10;
  localparam int unsigned ARX_STAT_RXR_B  = 11;
  localparam int unsigned ARX_STAT_STK_LSB = 16;

  // ******************************************************
  // Bit-time read state machine
  // ******************************************************
  typedef enum logic [3:0] {
    ARX_RIU_IDLE = 4'h1,
    ARX_RIU_REQ  = 4'h2,
    ARX_RIU_WAIT = 4'h4,
    ARX_RIU_DONE = 4'h8
  } arx_riu_st_t;

endpackage : arx_pkg

// ===== rtl/arx_ctrl_top.sv
// Delay control, bit-time read and test-channel monitor with APB registers
// Assumes one clock, the lane control unit and loopback channels outside
`timescale 1ns/1ns
module arx_ctrl_top #(
  parameter int unsigned NCH           = 3,
  parameter int unsigned W             = 8,
  parameter int unsigned NTXN          = 2,
  parameter int unsigned CNT_W         = 16,
  parameter bit          SIM_MODE_FLAG = 1'b0,
  parameter logic [5:0]  RIU_BT_ADDR   = 6'h00,
  parameter logic [1:0]  RIU_BT_NIB    = 2'h0
) (
  input  wire logic                  MCLK,
  input  wire logic                  RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output      logic [31:0]           PRDATA,
  output      logic                  PREADY,
  output      logic                  PSLVERR,
  output      logic                  IRQ,
  input  wire logic                  TOP_RESET_IN,
  output      logic                  RX_RESET,
  output      logic                  TX_RESET,
  output      logic                  RX_EN_VTC,
  output      logic                  TX_EN_VTC,
  input  wire logic [NTXN-1:0]       TX_DLY_RDY_NIB,
  output      logic                  TX_DLY_RDY,
  input  wire logic                  RX_DLY_RDY,
  output      logic [2*NCH-1:0]      RX_CE,
  output      logic [2*NCH-1:0]      RX_INC,
  output      logic [2*NCH-1:0]      RX_LOAD,
  output      logic [2*NCH*9-1:0]    RX_CNTVALUEIN,
  output      logic [5:0]            RIU_ADDR,
  output      logic [15:0]           RIU_WR_DATA,
  output      logic                  RIU_WR_EN,
  output      logic [1:0]            RIU_NIBBLE_SEL,
  input  wire logic [15:0]           RIU_RD_DATA,
  input  wire logic                  RIU_VALID,
  output      logic [8:0]            BIT_TIME_TAPS,
  output      logic [NCH*W-1:0]      TX_WORD,
  output      logic [NCH-1:0]        TX_VALID,
  input  wire logic [NCH*W-1:0]      RX_WORD,
  input  wire logic [NCH-1:0]        RX_VALID,
  output      logic [NCH-1:0]        PAT_VALID,
  output      logic [NCH-1:0]        ERR_PULSE
);
  arx_pkg::arx_riu_st_t riu_st_r, riu_st_nxt;
  logic [31:0]          ctrl_r, ctrl_nxt;
  logic [13:0]          dly_r, dly_nxt;
  logic [8:0]           bt_r, bt_nxt;
  logic                 btv_r, btv_nxt;
  logic                 bt_ev;
  logic [NCH:0]         istat_r, istat_nxt;
  logic [NCH:0]         imask_r, imask_nxt;
  logic [31:0]          prdata_r, prdata_nxt;
  logic                 txrdy_r, rxrst_r, txrst_r;
  logic [2*NCH*9-1:0]   cnt_val_r, cnt_val_nxt;
  logic [2*NCH-1:0]     load_r, load_nxt;
  logic                 wr_en, setup, hit;
  logic [31:0]          rd;
  logic [NCH-1:0]       sclr, crst, sticky_v, ep_v;
  logic [NCH*CNT_W-1:0] cnt_v;
  logic [8:0]           riu_dat, mon0_diff;

  // ******************************************************
  // APB decode
  // ******************************************************
  assign setup   = PSEL && !PENABLE;
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign PREADY  = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA  = prdata_r;

  always_comb begin
    rd  = '0;
    hit = 1'b1;
    unique case (PADDR)
      arx_pkg::ARX_OFF_CTRL:  rd = ctrl_r;
      arx_pkg::ARX_OFF_DLY:   rd = {18'h00000, dly_r};
      arx_pkg::ARX_OFF_STAT: begin
        rd[8:0] = bt_r;
        rd[arx_pkg::ARX_STAT_BTV_B] = btv_r;
        rd[arx_pkg::ARX_STAT_TXR_B] = txrdy_r;
        rd[arx_pkg::ARX_STAT_RXR_B] = RX_DLY_RDY;
        rd[arx_pkg::ARX_STAT_STK_LSB +: NCH] = sticky_v;
      end
      arx_pkg::ARX_OFF_ISTAT: rd[NCH:0] = istat_r;
      arx_pkg::ARX_OFF_IMASK: rd[NCH:0] = imask_r;
      default: begin
        hit = 1'b0;
        for (int c = 0; c < int'(NCH); c++) begin
          if (PADDR == arx_pkg::ARX_OFF_CNT0 + 8'(4 * c)) begin
            hit = 1'b1;
            rd[CNT_W-1:0] = cnt_v[c*CNT_W +: CNT_W];
          end
        end
      end
    endcase
  end

  // ******************************************************
  // Registers, pulses and interrupt status
  // ******************************************************
  assign sclr = (wr_en && PADDR == arx_pkg::ARX_OFF_CTRL)
                ? PWDATA[arx_pkg::ARX_CTRL_SCLR_LSB +: NCH] : '0;
  assign crst = (wr_en && PADDR == arx_pkg::ARX_OFF_CTRL)
                ? PWDATA[arx_pkg::ARX_CTRL_CRST_LSB +: NCH] : '0;

  always_comb begin
    ctrl_nxt   = ctrl_r;
    dly_nxt    = dly_r;
    imask_nxt  = imask_r;
    prdata_nxt = setup ? rd : prdata_r;
    istat_nxt  = istat_r;
    if (wr_en && PADDR == arx_pkg::ARX_OFF_CTRL) begin
      ctrl_nxt = PWDATA & arx_pkg::ARX_CTRL_WMASK;
    end
    if (wr_en && PADDR == arx_pkg::ARX_OFF_DLY) begin
      dly_nxt = PWDATA[13:0];
    end
    if (wr_en && PADDR == arx_pkg::ARX_OFF_IMASK) begin
      imask_nxt = PWDATA[NCH:0];
    end
    if (wr_en && PADDR == arx_pkg::ARX_OFF_ISTAT) begin
      istat_nxt = istat_r & ~PWDATA[NCH:0];
    end
    istat_nxt = istat_nxt | {ep_v, bt_ev};
  end

  assign IRQ = |(istat_r & imask_r);

  // ******************************************************
  // Bit-time read
  // ******************************************************
  assign riu_dat        = RIU_RD_DATA[8:0];
  assign RIU_ADDR       = RIU_BT_ADDR;
  assign RIU_NIBBLE_SEL = RIU_BT_NIB;
  assign RIU_WR_DATA    = '0;
  assign RIU_WR_EN      = 1'b0;

  always_comb begin
    riu_st_nxt = riu_st_r;
    bt_nxt     = bt_r;
    btv_nxt    = btv_r;
    bt_ev      = 1'b0;
    unique case (riu_st_r)
      arx_pkg::ARX_RIU_IDLE: begin
        if (wr_en && PADDR == arx_pkg::ARX_OFF_CTRL && PWDATA[arx_pkg::ARX_CTRL_REREAD_B]) begin
          riu_st_nxt = arx_pkg::ARX_RIU_REQ;
        end
      end
      arx_pkg::ARX_RIU_REQ: begin
        if (SIM_MODE_FLAG) begin
          bt_nxt     = arx_pkg::ARX_BT_SIM;
          btv_nxt    = 1'b1;
          riu_st_nxt = arx_pkg::ARX_RIU_DONE;
        end else begin
          riu_st_nxt = arx_pkg::ARX_RIU_WAIT;
        end
      end
      arx_pkg::ARX_RIU_WAIT: begin
        if (RIU_VALID) begin
          bt_nxt     = riu_dat;
          btv_nxt    = 1'b1;
          riu_st_nxt = arx_pkg::ARX_RIU_DONE;
        end
      end
      arx_pkg::ARX_RIU_DONE: begin
        bt_ev      = 1'b1;
        riu_st_nxt = arx_pkg::ARX_RIU_IDLE;
      end
      default: riu_st_nxt = arx_pkg::ARX_RIU_IDLE;
    endcase
  end

  assign BIT_TIME_TAPS = bt_r;

  // ******************************************************
  // Delay loads for active and monitor lanes
  // ******************************************************
  always_comb begin
    logic [8:0] act;
    logic [8:0] half;
    logic [1:0] ch;
    act         = PWDATA[8:0];
    half        = {1'b0, bt_r[8:1]};
    ch          = PWDATA[arx_pkg::ARX_DLY_CH_LSB +: 2];
    cnt_val_nxt = cnt_val_r;
    load_nxt    = '0;
    if (wr_en && PADDR == arx_pkg::ARX_OFF_DLY && int'(ch) < int'(NCH)) begin
      cnt_val_nxt[ch*18 +: 9] = act;
      cnt_val_nxt[ch*18 + 9 +: 9] = (act >= half) ? act - half : act + half;
      load_nxt[ch*2 +: 2] = 2'h3;
    end
  end

  assign RX_CE         = '0;
  assign RX_INC        = '0;
  assign RX_LOAD       = load_r;
  assign RX_CNTVALUEIN = cnt_val_r;

  // ******************************************************
  // Link resets and status
  // ******************************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      riu_st_r  <= arx_pkg::ARX_RIU_REQ;
      ctrl_r    <= arx_pkg::ARX_CTRL_RST;
      dly_r     <= arx_pkg::ARX_DLY_RST;
      bt_r      <= '0;
      btv_r     <= 1'b0;
      istat_r   <= '0;
      imask_r   <= '0;
      prdata_r  <= '0;
      txrdy_r   <= 1'b0;
      rxrst_r   <= 1'b1;
      txrst_r   <= 1'b1;
      cnt_val_r <= '0;
      load_r    <= '0;
    end else begin
      riu_st_r  <= riu_st_nxt;
      ctrl_r    <= ctrl_nxt;
      dly_r     <= dly_nxt;
      bt_r      <= bt_nxt;
      btv_r     <= btv_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      prdata_r  <= prdata_nxt;
      txrdy_r   <= &TX_DLY_RDY_NIB;
      rxrst_r   <= TOP_RESET_IN | ctrl_r[arx_pkg::ARX_CTRL_RXRST_B];
      txrst_r   <= TOP_RESET_IN | ctrl_r[arx_pkg::ARX_CTRL_TXRST_B];
      cnt_val_r <= cnt_val_nxt;
      load_r    <= load_nxt;
    end
  end

  assign TX_DLY_RDY = txrdy_r;
  assign RX_RESET   = rxrst_r;
  assign TX_RESET   = txrst_r;
  assign RX_EN_VTC  = ctrl_r[arx_pkg::ARX_CTRL_RXVTC_B];
  assign TX_EN_VTC  = ctrl_r[arx_pkg::ARX_CTRL_TXVTC_B];

  // ******************************************************
  // Test channels
  // ******************************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    arx_chk_if #(.W(W), .CNT_W(CNT_W)) u_if (.clk(MCLK), .rst(RST));
    assign u_if.inject     = ctrl_r[arx_pkg::ARX_CTRL_INJ_LSB + c];
    assign u_if.sticky_clr = sclr[c];
    assign u_if.chk_rst    = crst[c];
    assign u_if.rx_word    = RX_WORD[c*W +: W];
    assign u_if.rx_valid   = RX_VALID[c];
    assign TX_WORD[c*W +: W]         = u_if.tx_word;
    assign TX_VALID[c]               = u_if.tx_valid;
    assign PAT_VALID[c]              = u_if.pat_valid;
    assign ERR_PULSE[c]              = u_if.err_pulse;
    assign ep_v[c]                   = u_if.err_pulse;
    assign sticky_v[c]               = u_if.sticky;
    assign cnt_v[c*CNT_W +: CNT_W]   = u_if.err_cnt;
    arx_prbs_chk #(.W(W), .CNT_W(CNT_W)) u_chk (.ifc(u_if.chk));
  end

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  assign mon0_diff = (RX_CNTVALUEIN[8:0] >= RX_CNTVALUEIN[17:9])
                     ? RX_CNTVALUEIN[8:0] - RX_CNTVALUEIN[17:9]
                     : RX_CNTVALUEIN[17:9] - RX_CNTVALUEIN[8:0];

  property p_txrdy;
    !RST |=> (TX_DLY_RDY == &$past(TX_DLY_RDY_NIB));
  endproperty
  a_txrdy: assert property (p_txrdy) else $error("combined ready wrong");

  property p_nostep;
    (RX_CE == '0) && (RX_INC == '0);
  endproperty
  a_nostep: assert property (p_nostep) else $error("step control driven");

  property p_simbt;
    SIM_MODE_FLAG && btv_r |-> (BIT_TIME_TAPS == arx_pkg::ARX_BT_SIM);
  endproperty
  a_simbt: assert property (p_simbt) else $error("simulation bit time wrong");

  property p_riu;
    !SIM_MODE_FLAG && (riu_st_r == arx_pkg::ARX_RIU_WAIT) && RIU_VALID
      |=> (BIT_TIME_TAPS == $past(riu_dat)) ##1 istat_r[0];
  endproperty
  a_riu: assert property (p_riu) else $error("bit time not captured");

  property p_mon;
    RX_LOAD[0] && (bt_r[8:1] <= RX_CNTVALUEIN[8:0]) |-> (mon0_diff == {1'b0, bt_r[8:1]});
  endproperty
  a_mon: assert property (p_mon) else $error("monitor separation wrong");

  property p_rst;
    TOP_RESET_IN |=> RX_RESET && TX_RESET;
  endproperty
  a_rst: assert property (p_rst) else $error("top reset not applied");

endmodule : arx_ctrl_top

// ===== rtl/arx_prbs_chk.sv
// One looped-back test channel: pattern generator, error inject, checker
// Assumes the received word returns in the same bit order, msb first
`timescale 1ns/1ns
module arx_prbs_chk #(
  parameter int unsigned W     = 8,
  parameter int unsigned CNT_W = 16
) (
  arx_chk_if.chk ifc
);
  logic [6:0]       gen_r, gen_nxt;
  logic [6:0]       hist_r, hist_nxt;
  logic [W-1:0]     txw_r, txw_nxt;
  logic [W-1:0]     clean_r, clean_nxt;
  logic             pv_r, pv_nxt;
  logic             ep_r, ep_nxt;
  logic             st_r, st_nxt;
  logic             inj_d_r;
  logic             tv_r;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    logic [6:0] g;
    logic [6:0] h;
    logic       b;
    logic       err;
    g = gen_r;
    h = hist_r;
    b = 1'b0;
    err = 1'b0;
    txw_nxt = '0;
    for (int i = int'(W) - 1; i >= 0; i--) begin
      b = g[6] ^ g[5];
      txw_nxt[i] = b;
      g = {g[5:0], b};
    end
    gen_nxt = g;
    clean_nxt = txw_nxt;
    if (ifc.inject && !inj_d_r) begin
      txw_nxt[0] = ~txw_nxt[0];
    end
    if (ifc.rx_valid) begin
      for (int i = int'(W) - 1; i >= 0; i--) begin
        b = h[6] ^ h[5];
        err = err | (ifc.rx_word[i] ^ b);
        h = {h[5:0], ifc.rx_word[i]};
      end
    end
    hist_nxt = h;
    pv_nxt = ~pv_r;
    ep_nxt = err;
    st_nxt = (st_r & ~ifc.sticky_clr) | err;
    if (ifc.chk_rst) begin
      cnt_nxt = '0;
    end else if (err && (cnt_r != {CNT_W{1'b1}})) begin
      cnt_nxt = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge ifc.clk or posedge ifc.rst) begin
    if (ifc.rst) begin
      gen_r   <= arx_pkg::ARX_PRBS_SEED;
      hist_r  <= arx_pkg::ARX_PRBS_SEED;
      txw_r   <= '0;
      clean_r <= '0;
      pv_r    <= 1'b0;
      ep_r    <= 1'b0;
      st_r    <= 1'b0;
      inj_d_r <= 1'b0;
      tv_r    <= 1'b0;
      cnt_r   <= '0;
    end else begin
      gen_r   <= gen_nxt;
      hist_r  <= hist_nxt;
      txw_r   <= txw_nxt;
      clean_r <= clean_nxt;
      pv_r    <= pv_nxt;
      ep_r    <= ep_nxt;
      st_r    <= st_nxt;
      inj_d_r <= ifc.inject;
      tv_r    <= 1'b1;
      cnt_r   <= cnt_nxt;
    end
  end

  assign ifc.tx_word   = txw_r;
  assign ifc.tx_valid  = tv_r;
  assign ifc.pat_valid = pv_r;
  assign ifc.err_pulse = ep_r;
  assign ifc.sticky    = st_r;
  assign ifc.err_cnt   = cnt_r;

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge ifc.clk); endclocking
  default disable iff (ifc.rst);

  sequence s_inj_rise;
    ifc.inject && !inj_d_r;
  endsequence

  property p_inj;
    s_inj_rise |=> (ifc.tx_word != clean_r);
  endproperty
  a_inj: assert property (p_inj) else $error("inject did not corrupt word");

  property p_pv;
    !ifc.rst |=> (ifc.pat_valid != $past(ifc.pat_valid));
  endproperty
  a_pv: assert property (p_pv) else $error("pattern valid stopped toggling");

  property p_err_sticky;
    ifc.err_pulse |-> ifc.sticky;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error without sticky");

  property p_pulse;
    !ifc.rx_valid |=> !ifc.err_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("error pulse without word");

  property p_sat;
    (ifc.err_cnt == {CNT_W{1'b1}}) && !ifc.chk_rst |=> (ifc.err_cnt == {CNT_W{1'b1}});
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");

  property p_crst;
    ifc.chk_rst |=> (ifc.err_cnt == '0);
  endproperty
  a_crst: assert property (p_crst) else $error("checker reset left count");

  property p_sclr;
    ifc.sticky_clr ##1 !ifc.err_pulse |-> !ifc.sticky;
  endproperty
  a_sclr: assert property (p_sclr) else $error("sticky not cleared");

  property p_hold;
    ifc.sticky && !ifc.sticky_clr |=> ifc.sticky;
  endproperty
  a_hold: assert property (p_hold) else $error("sticky dropped by itself");

endmodule : arx_prbs_chk
